/* File: rmcg_pkg.sv */
`default_nettype none
package rmcg_pkg;

	// Register byte offsets inside the system control window.
	localparam logic [11:0] OFS_RUN_ENABLE = 12'h104;
	localparam logic [11:0] OFS_SLEEP_ENABLE = 12'h114;
	localparam logic [11:0] OFS_DEEP_ENABLE = 12'h124;
	localparam logic [11:0] OFS_CLOCK_CONFIG = 12'h060;
	localparam logic [11:0] OFS_FAULT_STATUS = 12'h140;
	localparam logic [11:0] OFS_FAULT_MASK = 12'h144;

	// Gate bit positions in every gating register, and the auto gating bit of the clock configuration register.
	localparam int BIT_UART_UNIT_ZERO_GATE = 0;
	localparam int BIT_UART_UNIT_ONE_GATE = 1;
	localparam int BIT_SYNC_SERIAL_ZERO_GATE = 4;
	localparam int BIT_I2C_UNIT_ZERO_GATE = 12;
	localparam int BIT_GP_COUNTER_ZERO_GATE = 16;
	localparam int BIT_GP_COUNTER_ONE_GATE = 17;
	localparam int BIT_GP_COUNTER_TWO_GATE = 18;
	localparam int BIT_ANALOG_COMPARATOR_ZERO_GATE = 24;
	localparam int BIT_AUTO_CLOCK_GATING_SELECT = 0;

	// Number of gated units, index order follows the table below.
	localparam int NUM_UNITS = 8;
	localparam int UNIT_BIT [NUM_UNITS] = '{
		BIT_UART_UNIT_ZERO_GATE, BIT_UART_UNIT_ONE_GATE,
		BIT_SYNC_SERIAL_ZERO_GATE, BIT_I2C_UNIT_ZERO_GATE,
		BIT_GP_COUNTER_ZERO_GATE, BIT_GP_COUNTER_ONE_GATE,
		BIT_GP_COUNTER_TWO_GATE, BIT_ANALOG_COMPARATOR_ZERO_GATE};

	// Writable bits and reset values.
	localparam logic [31:0] GATE_WRITE_MASK = 32'h0107_1013;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Complete state of the block apart from the clock gate flops.
	typedef struct packed {
		logic [31:0] run;
		logic [31:0] slp;
		logic [31:0] dsl;
		logic auto_clock_gating_select;
		logic [7:0] sts;
		logic [7:0] msk;
		logic [31:0] rdata;
		logic err;
	} rmcg_state_t;

	// Gathers the per-unit enable bits of a gating register.
	function automatic logic [NUM_UNITS-1:0] rmcg_pick(input logic [31:0] r);
		logic [NUM_UNITS-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_UNITS; i++) begin
			v[i] = r[UNIT_BIT[i]];
		end
		return v;
	endfunction

endpackage
`default_nettype wire

/* File: rmcg_gate.sv */
`timescale 1ns/10ps
`default_nettype none
module rmcg_gate (
	input wire logic pclk, // System clock, 20 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic pready, // APB ready.
	output logic [31:0] prdata, // APB read data.
	output logic pslverr, // APB error for unmapped address.
	input wire logic sleep_req, // System is in sleep mode.
	input wire logic deep_sleep_req, // System is in deep-sleep mode.
	input wire logic [rmcg_pkg::NUM_UNITS-1:0] unit_access, // Bus access to unit.
	output logic [rmcg_pkg::NUM_UNITS-1:0] unit_fault, // Bus fault to unit access.
	output logic [rmcg_pkg::NUM_UNITS-1:0] unit_clk_en, // Unit enabled level.
	output logic [rmcg_pkg::NUM_UNITS-1:0] unit_clk, // Gated unit clocks.
	output logic irq // Unmasked fault status pending.
);
	import rmcg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	rmcg_state_t cur_ff;
	rmcg_state_t nxt_ff;
	logic setup;
	logic wr_access;
	logic hit;
	logic [31:0] rd_mux;
	logic [31:0] sel_reg;
	logic [NUM_UNITS-1:0] unit_en;
	logic [NUM_UNITS-1:0] gate_en_ff;

	// Bus phases: setup samples read data, access commits writes.
	assign setup = psel & ~penable;
	assign wr_access = psel & penable & pwrite;

	// Address decode and read multiplexer.
	always_comb begin
		hit = 1'b1;
		rd_mux = READ_ZERO;
		unique case (paddr)
			OFS_RUN_ENABLE: begin
				rd_mux = cur_ff.run;
			end
			OFS_SLEEP_ENABLE: begin
				rd_mux = cur_ff.slp;
			end
			OFS_DEEP_ENABLE: begin
				rd_mux = cur_ff.dsl;
			end
			OFS_CLOCK_CONFIG: begin
				rd_mux[BIT_AUTO_CLOCK_GATING_SELECT] = cur_ff.auto_clock_gating_select;
			end
			OFS_FAULT_STATUS: begin
				rd_mux[NUM_UNITS-1:0] = cur_ff.sts;
			end
			OFS_FAULT_MASK: begin
				rd_mux[NUM_UNITS-1:0] = cur_ff.msk;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Power mode picks which gating register drives the units.
	always_comb begin
		if (cur_ff.auto_clock_gating_select && deep_sleep_req) begin
			sel_reg = cur_ff.dsl;
		end else if (cur_ff.auto_clock_gating_select && sleep_req) begin
			sel_reg = cur_ff.slp;
		end else begin
			sel_reg = cur_ff.run;
		end
		unit_en = rmcg_pick(sel_reg);
	end

	// Next state of registers, read data and fault status.
	always_comb begin
		nxt_ff = cur_ff;
		if (setup) begin
			nxt_ff.err = ~hit;
			nxt_ff.rdata = (pwrite || !hit) ? READ_ZERO : rd_mux;
		end
		if (wr_access && hit) begin
			unique case (paddr)
				OFS_RUN_ENABLE: begin
					nxt_ff.run = pwdata & GATE_WRITE_MASK;
				end
				OFS_SLEEP_ENABLE: begin
					nxt_ff.slp = pwdata & GATE_WRITE_MASK;
				end
				OFS_DEEP_ENABLE: begin
					nxt_ff.dsl = pwdata & GATE_WRITE_MASK;
				end
				OFS_CLOCK_CONFIG: begin
					nxt_ff.auto_clock_gating_select = pwdata[BIT_AUTO_CLOCK_GATING_SELECT];
				end
				OFS_FAULT_STATUS: begin
					nxt_ff.sts = cur_ff.sts & ~pwdata[NUM_UNITS-1:0];
				end
				OFS_FAULT_MASK: begin
					nxt_ff.msk = pwdata[NUM_UNITS-1:0];
				end
				default: begin
					nxt_ff.err = cur_ff.err;
				end
			endcase
		end
		// A new fault wins over a clear in the same cycle.
		nxt_ff.sts = nxt_ff.sts | (unit_access & ~unit_en);
	end

	// State register; everything starts unclocked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_ff.run <= GATE_RESET;
			cur_ff.slp <= GATE_RESET;
			cur_ff.dsl <= GATE_RESET;
			cur_ff.auto_clock_gating_select <= 1'b0;
			cur_ff.sts <= FAULT_RESET;
			cur_ff.msk <= FAULT_RESET;
			cur_ff.rdata <= READ_ZERO;
			cur_ff.err <= 1'b0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enables change only while the clock is low, so no pulse is cut short.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi++) begin : g_gate
			always_ff @(negedge pclk or negedge presetn) begin
				if (!presetn) begin
					gate_en_ff[gi] <= 1'b0;
				end else begin
					gate_en_ff[gi] <= unit_en[gi];
				end
			end
			assign unit_clk[gi] = pclk & gate_en_ff[gi];
		end
	endgenerate

	// Outputs toward the bus, the units and the interrupt line.
	assign pready = 1'b1;
	assign prdata = cur_ff.rdata;
	assign pslverr = cur_ff.err;
	assign unit_clk_en = unit_en;
	assign unit_fault = unit_access & ~unit_en;
	assign irq = |(cur_ff.sts & cur_ff.msk);

	////////////////////////////////////////////////////////////////////////////
	// Checks on the block's own behaviour.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Holds reset contents while reset is low.
	reset_clear_a: assert property (disable iff (1'b0)
		!presetn |-> (cur_ff.run == GATE_RESET) && (unit_clk_en == '0))
		else $error("Gating register not zero in reset.");

	// A run write lands masked one cycle later.
	run_write_a: assert property (
		(wr_access && paddr == OFS_RUN_ENABLE)
		|=> cur_ff.run == ($past(pwdata) & GATE_WRITE_MASK))
		else $error("Run enable write not stored.");

	// Unused bits never become set.
	reserved_zero_a: assert property (
		((cur_ff.run | cur_ff.slp | cur_ff.dsl) & ~GATE_WRITE_MASK) == '0)
		else $error("Reserved gating bit set.");

	// A faulted access is recorded in status the next cycle.
	fault_sticky_a: assert property (
		(|(unit_access & ~unit_en))
		|=> (cur_ff.sts & $past(unit_access & ~unit_en)) == $past(unit_access & ~unit_en))
		else $error("Fault not recorded.");

	// Without auto gating, an access to a unit off in the run register is answered with a bus fault.
	fault_answer_a: assert property (
		(|(unit_access & ~rmcg_pick(cur_ff.run))) && !cur_ff.auto_clock_gating_select |-> |unit_fault)
		else $error("Access to unclocked unit not faulted.");

	// Deep sleep uses the deep-sleep register only with auto gating.
	deep_select_a: assert property (
		cur_ff.auto_clock_gating_select && deep_sleep_req |-> unit_clk_en == rmcg_pick(cur_ff.dsl))
		else $error("Deep-sleep enables not applied.");

	// Without auto gating the run register always applies.
	run_select_a: assert property (
		!cur_ff.auto_clock_gating_select |-> unit_clk_en == rmcg_pick(cur_ff.run))
		else $error("Run enables not applied.");

	// Comparator follows bit 24 in run mode one cycle after a write.
	comp_bit_a: assert property (
		(wr_access && paddr == OFS_RUN_ENABLE) ##1 (!cur_ff.auto_clock_gating_select)
		|-> unit_clk_en[7] == $past(pwdata[BIT_ANALOG_COMPARATOR_ZERO_GATE]))
		else $error("Comparator gate bit mismatch.");

	// Gate flop holds the enable seen during the low phase.
	gate_sync_a: assert property (
		gate_en_ff == unit_en)
		else $error("Clock gate out of step with enable.");

	// Masked pending status raises the interrupt, and nothing else does.
	irq_level_a: assert property (
		irq == |(cur_ff.sts & cur_ff.msk))
		else $error("Interrupt level wrong.");

	// Sleep without deep sleep uses the sleep register only with auto gating.
	sleep_select_a: assert property (
		cur_ff.auto_clock_gating_select && sleep_req && !deep_sleep_req |-> unit_clk_en == rmcg_pick(cur_ff.slp))
		else $error("Sleep enables not applied.");

	// A sleep register write lands masked one cycle later.
	slp_write_a: assert property (
		(wr_access && paddr == OFS_SLEEP_ENABLE)
		|=> cur_ff.slp == ($past(pwdata) & GATE_WRITE_MASK))
		else $error("Sleep enable write not stored.");

	// A deep-sleep register write lands masked one cycle later.
	dsl_write_a: assert property (
		(wr_access && paddr == OFS_DEEP_ENABLE)
		|=> cur_ff.dsl == ($past(pwdata) & GATE_WRITE_MASK))
		else $error("Deep-sleep enable write not stored.");

	// The auto gating bit follows its write.
	acg_write_a: assert property (
		(wr_access && paddr == OFS_CLOCK_CONFIG)
		|=> cur_ff.auto_clock_gating_select == $past(pwdata[BIT_AUTO_CLOCK_GATING_SELECT]))
		else $error("Auto gating bit not stored.");

	// A read of the run register returns its contents.
	run_read_a: assert property (
		(setup && !pwrite && paddr == OFS_RUN_ENABLE)
		|=> prdata == $past(cur_ff.run))
		else $error("Run enable read wrong.");

	// An unmapped address answers with an error and zero data.
	bad_addr_a: assert property (
		(setup && !hit) |=> pslverr && (prdata == READ_ZERO))
		else $error("Unmapped access not refused.");

	// A write to an unmapped address leaves the run register alone.
	bad_write_a: assert property (
		(wr_access && !hit) |=> $stable(cur_ff.run))
		else $error("Unmapped write changed run enables.");

	// The bus never waits.
	ready_high_a: assert property (
		pready)
		else $error("Ready not high.");

	// UART gates follow bits 1 and 0 in run mode.
	uart_bits_a: assert property (
		!cur_ff.auto_clock_gating_select |-> unit_clk_en[1:0] ==
		{cur_ff.run[BIT_UART_UNIT_ONE_GATE], cur_ff.run[BIT_UART_UNIT_ZERO_GATE]})
		else $error("UART gate bits mismatch.");

	// Counter gates follow bits 18 to 16 in run mode.
	timer_bits_a: assert property (
		!cur_ff.auto_clock_gating_select |->
		unit_clk_en[6:4] == cur_ff.run[BIT_GP_COUNTER_TWO_GATE:BIT_GP_COUNTER_ZERO_GATE])
		else $error("Counter gate bits mismatch.");

	// The I2C gate follows bit 12 in run mode.
	i2c_bit_a: assert property (
		!cur_ff.auto_clock_gating_select |-> unit_clk_en[3] == cur_ff.run[BIT_I2C_UNIT_ZERO_GATE])
		else $error("I2C gate bit mismatch.");

	// The serial gate follows bit 4 in run mode.
	serial_bit_a: assert property (
		!cur_ff.auto_clock_gating_select |-> unit_clk_en[2] == cur_ff.run[BIT_SYNC_SERIAL_ZERO_GATE])
		else $error("Serial gate bit mismatch.");

	// Status holds when there is neither a write nor a fault.
	status_keep_a: assert property (
		!wr_access && !(|(unit_access & ~unit_en)) |=> $stable(cur_ff.sts))
		else $error("Fault status changed by itself.");

	// Writing ones clears status bits when no new fault arrives.
	fault_clear_a: assert property (
		(wr_access && paddr == OFS_FAULT_STATUS && !(|(unit_access & ~unit_en)))
		|=> (cur_ff.sts & $past(pwdata[NUM_UNITS-1:0])) == '0)
		else $error("Fault status not cleared.");

	// Main scenarios.
	cov_fault: cover property (|unit_fault ##1 irq);
	cov_deep: cover property (cur_ff.auto_clock_gating_select && deep_sleep_req && |unit_clk_en);
	cov_run_on: cover property (wr_access && paddr == OFS_RUN_ENABLE ##1 |unit_clk_en);
	cov_bad_addr: cover property (setup && !hit ##1 pslverr);
	cov_sleep: cover property (cur_ff.auto_clock_gating_select && sleep_req && !deep_sleep_req);

endmodule
`default_nettype wire

/* File: rmcg_cpu.sv */
`timescale 1ns/10ps
`default_nettype none
module rmcg_cpu (
	input wire logic pclk, // System clock.
	output logic psel, // Select.
	output logic penable, // Access phase.
	output logic pwrite, // High for write.
	output logic [11:0] paddr, // Byte address.
	output logic [31:0] pwdata, // Write data.
	input wire logic pready, // Ready.
	input wire logic [31:0] prdata, // Read data.
	input wire logic pslverr, // Error.
	output logic hung // A transfer never ended.
);
	// The bus starts idle.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		hung = 1'b0;
	end
	// One transfer; the answer is taken at the edge that sees pready, or after 50 edges without it.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) hung <= 1'b1;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rmcg_pkg::*;
	logic pclk, presetn, sleep_req, deep_sleep_req, psel, penable, pwrite;
	logic pready, pslverr, irq, hung, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, model_run, d;
	logic [NUM_UNITS-1:0] unit_access, unit_fault, unit_clk_en, unit_clk;
	integer seed = 32'h4D16;
	int mismatches = 0;
	int n_checks = 0;
	rmcg_gate dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
		.unit_access(unit_access), .unit_fault(unit_fault), .unit_clk_en(unit_clk_en),
		.unit_clk(unit_clk), .irq(irq));
	rmcg_cpu cpu_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .hung(hung));
	////////////////////////////////////////////////////////////////////////////////
	// Clock of 50 ns.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	// Expected unit enables from a gating register value.
	function automatic logic [7:0] en_of(input logic [31:0] r);
		for (int i = 0; i < NUM_UNITS; i++) en_of[i] = r[UNIT_BIT[i]];
	endfunction
	// Register write and checked read.
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		cpu_u.xfer(1'b1, a, v, rd, err);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		cpu_u.xfer(1'b0, a, 32'h0000_0000, rd, err);
		chk("read", e, rd);
	endtask
	// One cycle of unit accesses, checking enables and faults.
	task automatic acc(input logic [7:0] a, input logic [7:0] en);
		@(posedge pclk);
		unit_access <= a;
		@(negedge pclk);
		chk("enable", {24'h0, en}, {24'h0, unit_clk_en});
		chk("fault", {24'h0, a & ~en}, {24'h0, unit_fault});
		@(posedge pclk);
		unit_access <= 8'h00;
	endtask
	task automatic print_verdict();
		if (hung) mismatches++;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		presetn = 1'b0;
		sleep_req = 1'b0;
		deep_sleep_req = 1'b0;
		unit_access = 8'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_RUN_ENABLE, 32'h0000_0000);
		acc(8'hFF, 8'h00);
		$display("reset test ended");
		for (int i = 0; i < 16; i++) begin
			d = (i < 8) ? (32'hFEF8_EFEC | (32'h1 << UNIT_BIT[i])) : $random(seed);
			wr(OFS_RUN_ENABLE, d);
			model_run = d & 32'h0107_1013;
			rdc(OFS_RUN_ENABLE, model_run);
			acc(8'($random(seed)), en_of(model_run));
		end
		cpu_u.xfer(1'b0, 12'h200, 32'h0, rd, err);
		chk("unmapped", 32'h1, {31'h0, err});
		cpu_u.xfer(1'b0, OFS_RUN_ENABLE, 32'h0000_0000, rd, err);
		wr(OFS_RUN_ENABLE, rd | 32'h0000_0001);
		rdc(OFS_RUN_ENABLE, model_run | 32'h0000_0001);
		$display("register test ended");
		wr(OFS_RUN_ENABLE, 32'h0);
		wr(OFS_FAULT_STATUS, 32'hFF);
		wr(OFS_FAULT_MASK, 32'h01);
		acc(8'h01, 8'h00);
		rdc(OFS_FAULT_STATUS, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_FAULT_MASK, 32'h0);
		rdc(OFS_FAULT_MASK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(OFS_FAULT_MASK, 32'h01);
		wr(OFS_FAULT_STATUS, 32'h01);
		rdc(OFS_FAULT_STATUS, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		$display("fault test ended");
		wr(OFS_RUN_ENABLE, 32'h0107_1013);
		sleep_req <= 1'b1;
		acc(8'h00, 8'hFF);
		wr(OFS_CLOCK_CONFIG, 32'h1);
		acc(8'hFF, 8'h00);
		wr(OFS_DEEP_ENABLE, 32'h0000_0011);
		deep_sleep_req <= 1'b1;
		acc(8'h00, 8'h05);
		$display("mode test ended");
		print_verdict();
	end
endmodule
`default_nettype wire
